//--- dv/dsl_monitor.sv
// checker for the supervisory block, watching top-level ports only
// assumes it is bound into dsl_top from the bench top file
`timescale 1ns/1ns
module dsl_monitor (
  input wire logic                I_CORE_CLK,
  input wire logic                I_SRST,
  input wire dsl_pkg::dsl_plant_t I_PLANT,
  input wire logic [2:0]          I_KEYS,
  input wire logic                O_PREADY,
  input wire logic                O_PSLVERR,
  input wire logic                O_FAST_LIMIT_EN,
  input wire logic                O_DEADBAND_EN,
  input wire logic                O_LIMIT_ALARM,
  input wire logic                O_SLEEPING,
  input wire logic                O_OC_FAULT,
  input wire logic                O_FAN_ON,
  input wire logic                O_JOG_FWD,
  input wire logic                O_JOG_REV,
  input wire logic                O_HALT,
  input wire logic [15:0]         O_DISP_MASK
);
  // ----------------------------------------------------------------
  // properties; windows of 6 or 8 cover the three-flop pin synchroniser
  // ----------------------------------------------------------------
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("pready stuck");
  a_err_needs_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("lone pslverr");
  a_reset_defaults: assert property ($fell(I_SRST) |-> O_FAST_LIMIT_EN && O_DEADBAND_EN)
    else $error("bad defaults");
  a_alarm_cause: assert property (!I_PLANT.fast_limit_active [*8] |-> !O_LIMIT_ALARM)
    else $error("stray alarm");
  a_sleep_needs_run: assert property (!I_PLANT.run_cmd [*8] |-> !O_SLEEPING)
    else $error("stray sleep");
  a_fan_running: assert property (I_PLANT.run_cmd [*8] |-> O_FAN_ON)
    else $error("fan off");
  a_stop_mask_width: assert property (!I_PLANT.run_cmd [*8] |-> O_DISP_MASK[15:9] == 7'h00)
    else $error("wide stop mask");
  a_jog_needs_key: assert property (!I_KEYS[2] [*6] |-> !O_JOG_FWD && !O_JOG_REV)
    else $error("stray jog");
  a_halt_pulse: assert property (O_HALT |=> !O_HALT)
    else $error("long halt");
  a_halt_cause: assert property (O_HALT |-> $past(I_KEYS[0], 3) || $past(I_KEYS[0], 6))
    else $error("stray halt");
  c_sleep: cover property (O_SLEEPING);
  c_fault: cover property (O_OC_FAULT);
  c_halt: cover property (O_HALT);
endmodule

//--- dv/dsl_plant_model.sv
// behavioural motor stage and keypad facing the supervisory block
// assumes the bench calls its tasks just after rising clock edges
`timescale 1ns/1ns
module dsl_plant_model (
  input  wire logic           clk,
  input  wire logic           sleeping,
  input  wire logic           limit_en,
  output dsl_pkg::dsl_plant_t plant,
  output logic [2:0]          keys
);
  logic        run = 1'b0;
  logic        hot = 1'b0;
  logic [15:0] setf = 16'h0000;
  logic [15:0] cur = 16'h0000;
  // stage output is zero asleep; limiter engages above 300 percent
  assign plant = '{run, limit_en && cur > 16'h0bb8, hot, setf,
                   (run && !sleeping) ? setf : 16'h0000, cur};
  initial keys = 3'h0;
  task op(input logic r, input logic h, input logic [15:0] f, input logic [15:0] c);
    run <= r;
    hot <= h;
    setf <= f;
    cur <= c;
  endtask
  // jog drives both of its pins, k zero is the halt key
  task press(input int k, input int n);
    keys <= (k == 0) ? 3'h1 : 3'h6;
    repeat (n) @(posedge clk);
    keys <= 3'h0;
    @(posedge clk);
  endtask
endmodule

//--- dv/dsl_top_tb.sv
// self-checking bench for the supervisory block over its apb port
// assumes the plant model and monitor are compiled before this file
`timescale 1ns/1ns
module dsl_top_tb;
  logic                clk = 1'b0;
  logic                srst = 1'b1;
  dsl_pkg::dsl_apb_t   req = '0;
  dsl_pkg::dsl_plant_t plant;
  logic [2:0]          keys;
  logic [31:0]         prdata, rd;
  logic [15:0]         disp;
  logic pready, pslverr, err, smod, fl_en, alarm, slp, oc, db_en, fan, pid, kp, rev, jf, jr, halt;
  logic                halt_seen = 1'b0;
  int                  miscompares = 0;
  int                  check_count = 0;
  int                  cyc = 0;
  always #20 clk = ~clk;
  // short ticks keep every delay brief
  dsl_top #(.TICK_CYC(4), .LIMIT_TICKS(5), .HOUR_TICKS(10), .FAN_TICKS(5)) u_dsl_top (
    .I_CORE_CLK(clk), .I_SRST(srst), .I_APB(req), .I_PLANT(plant), .I_KEYS(keys),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PRDATA(prdata), .O_SYNC_MOD(smod),
    .O_FAST_LIMIT_EN(fl_en), .O_LIMIT_ALARM(alarm), .O_SLEEPING(slp), .O_OC_FAULT(oc),
    .O_DEADBAND_EN(db_en), .O_FAN_ON(fan), .O_PID_RUN(pid), .O_KEYPAD_SRC(kp),
    .O_REVERSE(rev), .O_JOG_FWD(jf), .O_JOG_REV(jr), .O_HALT(halt), .O_DISP_MASK(disp));
  dsl_plant_model u_dsl_plant_model (.clk(clk), .sleeping(slp), .limit_en(fl_en),
    .plant(plant), .keys(keys));
  task end_sim();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task op(input logic r, input logic [15:0] f, input logic [15:0] c);
    u_dsl_plant_model.op(r, 1'b0, f, c);
  endtask
  task key(input int k, input int n);
    u_dsl_plant_model.press(k, n);
  endtask
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (halt) halt_seen <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    wt(10);
    srst <= 1'b0;
    wt(1);
    rchk(dsl_pkg::OFS_CTRL, 32'h2006);
    rchk(dsl_pkg::OFS_RUN_MASK, 32'h3f);
    rchk(dsl_pkg::OFS_STOP_MASK, 32'h3);
    rchk(dsl_pkg::OFS_SOC, 32'h7d0);
    rchk(dsl_pkg::OFS_SPEED, 32'h2710);
    chk(disp, 32'h3);
    wr(dsl_pkg::OFS_HOURS, 32'hffff);
    rchk(dsl_pkg::OFS_HOURS, 32'h0);
    rchk(8'h2c, 32'h0);
    chk(err, 32'h1);
    wr(dsl_pkg::OFS_CTRL, 32'h202f);
    wt(2);
    chk({smod, pid, fan}, 32'h7);
    wr(dsl_pkg::OFS_CTRL, 32'h2000);
    wt(2);
    chk({smod, fl_en, db_en, pid}, 32'h0);
    wr(dsl_pkg::OFS_CTRL, 32'h2006);
    wr(dsl_pkg::OFS_SPEED, 32'h4e20);
    wr(dsl_pkg::OFS_STOP_MASK, 32'h1ff);
    wr(dsl_pkg::OFS_RUN_MASK, 32'ha5a5);
    op(1'b0, 16'h1388, 16'h0);
    wt(8);
    rchk(dsl_pkg::OFS_LOAD, 32'h2710);
    chk(disp, 32'h1ff);
    op(1'b1, 16'h0fa0, 16'h0);
    wt(8);
    rchk(dsl_pkg::OFS_LOAD, 32'h1f40);
    chk(disp, 32'ha5a5);
    op(1'b0, 16'h0fa0, 16'h0);
    wt(10);
    chk(fan, 32'h1);
    wt(40);
    chk(fan, 32'h0);
    // overcurrent: held, too short, then with zero delay
    wr(dsl_pkg::OFS_SOC, {16'h3, 16'h03e8});
    op(1'b1, 16'h0fa0, 16'h05dc);
    wt(30);
    chk(oc, 32'h1);
    op(1'b1, 16'h0fa0, 16'h0);
    wt(8);
    op(1'b1, 16'h0fa0, 16'h05dc);
    wt(6);
    op(1'b1, 16'h0fa0, 16'h0);
    wt(30);
    chk(oc, 32'h0);
    wr(dsl_pkg::OFS_SOC, {16'h0, 16'h03e8});
    op(1'b1, 16'h0fa0, 16'h0dac);
    wt(40);
    chk({alarm, oc}, 32'h2);
    op(1'b1, 16'h0fa0, 16'h0);
    wt(8);
    chk(alarm, 32'h0);
    // sleep and wake with wake above sleep
    wr(dsl_pkg::OFS_WAKE, {16'h2, 16'h0bb8});
    wr(dsl_pkg::OFS_SLEEP, {16'h1, 16'h03e8});
    op(1'b1, 16'h01f4, 16'h0);
    wt(60);
    chk(slp, 32'h1);
    op(1'b1, 16'h0dac, 16'h0);
    wt(40);
    chk(slp, 32'h1);
    wt(60);
    chk(slp, 32'h0);
    wr(dsl_pkg::OFS_WAKE, {16'h2, 16'h0});
    wr(dsl_pkg::OFS_SLEEP, {16'h1, 16'h0});
    op(1'b1, 16'h0, 16'h0);
    wt(80);
    chk(slp, 32'h0);
    // keys: remote source first, then keypad source
    key(0, 8);
    wt(4);
    chk(halt_seen, 32'h0);
    wr(dsl_pkg::OFS_CTRL, 32'h2206);
    key(1, 8);
    chk({kp, rev}, 32'h0);
    wr(dsl_pkg::OFS_CTRL, 32'h2106);
    key(1, 8);
    chk(kp, 32'h1);
    wr(dsl_pkg::OFS_CTRL, 32'h2206);
    key(1, 8);
    chk(rev, 32'h1);
    key(0, 8);
    wt(4);
    chk(halt_seen, 32'h1);
    for (int m = 3; m < 5; m++) begin
      wr(dsl_pkg::OFS_CTRL, 32'h2006 | (m << 8));
      fork
        key(1, 12);
        begin
          wt(8);
          chk({jf, jr}, (m == 3) ? 32'h2 : 32'h1);
        end
      join
    end
    end_sim();
  end
endmodule
bind dsl_top dsl_monitor u_dsl_monitor (.*);

//--- hw/dsl_delay_timer.sv
// delay qualifier: a condition must hold for a set number of ticks
// assumes tick is a one-cycle enable on the same clock
`timescale 1ns/1ns
module dsl_delay_timer #(
  parameter int W = 20
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         tick,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  output logic              expired
);
  logic [W-1:0] count;

  // count while the condition holds; a lapse restarts from zero
  always_ff @(posedge clk) begin
    if (srst || !cond) begin
      count   <= '0;                     // see R23
      expired <= 1'b0;
    end else if (count >= limit) begin
      expired <= 1'b1;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end
endmodule

//--- hw/dsl_pkg.sv
// package for the drive supervisory logic: register map, fields, timing
// assumes a 25 MHz core clock and an apb slave with 32-bit data
package dsl_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_WAKE      = 8'h04;
  localparam logic [7:0] OFS_SLEEP     = 8'h08;
  localparam logic [7:0] OFS_SOC       = 8'h0c;
  localparam logic [7:0] OFS_SPEED     = 8'h10;
  localparam logic [7:0] OFS_RUN_MASK  = 8'h14;
  localparam logic [7:0] OFS_STOP_MASK = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1c;
  localparam logic [7:0] OFS_HOURS     = 8'h20;
  localparam logic [7:0] OFS_LOAD      = 8'h24;
  localparam logic [7:0] OFS_VERSION   = 8'h28;

  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MOD_BIT   = 0;
  localparam int CTRL_FCL_BIT   = 1;
  localparam int CTRL_DBC_BIT   = 2;
  localparam int CTRL_FAN_BIT   = 3;
  localparam int CTRL_STOPK_BIT = 4;
  localparam int CTRL_PID_BIT   = 5;
  localparam int CTRL_JOG_LSB   = 8;
  localparam int CTRL_DEC_LSB   = 12;

  // ----------------------------------------------------------------
  // reset values and run hours ceiling
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET      = 32'h0000_2006;
  localparam logic [15:0] SOC_THR_RESET   = 16'h07d0;
  localparam logic [15:0] FACTOR_RESET    = 16'h2710;
  localparam logic [15:0] RUN_MASK_RESET  = 16'h003f;
  localparam logic [8:0]  STOP_MASK_RESET = 9'h003;
  localparam logic [15:0] HOURS_MAX       = 16'hffff;

  // ----------------------------------------------------------------
  // timing: tick periods in their own units, cycles derived from clock
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 25_000_000;
  localparam int TICK_10MS_MS    = 10;
  localparam int TICK_10MS_CYC   = CLK_HZ / 1000 * TICK_10MS_MS;
  localparam int FAN_HOLD_S      = 10;
  localparam int FAN_HOLD_TICKS  = FAN_HOLD_S * 100;
  localparam int HOUR_S          = 3600;
  localparam int HOUR_TICKS      = HOUR_S * 100;
  localparam int LIMIT_ALARM_S   = 60;
  localparam int LIMIT_TICKS     = LIMIT_ALARM_S * 100;

  // jog key modes
  typedef enum logic [2:0] {
    JOG_OFF, JOG_SRC_TOGGLE, JOG_DIR_TOGGLE, JOG_FWD, JOG_REV
  } dsl_jog_t;

  // key events from the keypad
  typedef struct packed {
    logic jog_press;
    logic jog_release;
    logic halt_press;
  } dsl_keys_t;

  // plant status inputs
  typedef struct packed {
    logic        run_cmd;
    logic        fast_limit_active;
    logic        hot;
    logic [15:0] set_freq;
    logic [15:0] out_freq;
    logic [15:0] out_current;
  } dsl_plant_t;

  // apb request
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dsl_apb_t;

endpackage

//--- hw/dsl_top.sv
// top of the drive supervisory logic with its apb register file
// assumes one 25 MHz clock, synchronous reset and pins that need syncing
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
// Functional notes
// R1: modulation select one gives synchronous carrier
// R2: fast current limit enable, default on
// R3: prolonged fast limiting raises overload alarm
// R4: low set frequency for delay enters sleep
// R5: in sleep, high set frequency wakes
// R6: both frequencies zero disables sleep
// R7: software keeps sleep below wake frequency
// R8: software enables pid computation when sleeping
// R9: overcurrent above threshold past delay faults
// R10: zero overcurrent delay disables detection
// R11: deadband compensation select, default on
// R12: fan mode zero: hold ten seconds, then temperature
// R13: fan mode one: fan always runs
// R14: running load speed from output frequency
// R15: stopped load speed from set frequency
// R16: run hours counter, read only
// R17: mask bits gate displayed values
// R18: run mask bits follow sixteen values
// R19: stop mask bits follow nine values
// R20: jog key function selector decoding
// R21: direction toggle only under keypad source
// R22: stop key scope selects honoured modes
// R23: delay timers restart when condition lapses
// R24: pid compute when stopped selector
module dsl_top #(
  parameter int          TICK_CYC    = dsl_pkg::TICK_10MS_CYC,
  parameter int          LIMIT_TICKS = dsl_pkg::LIMIT_TICKS,
  parameter int          HOUR_TICKS  = dsl_pkg::HOUR_TICKS,
  parameter int          FAN_TICKS   = dsl_pkg::FAN_HOLD_TICKS,
  parameter logic [15:0] VERSION     = 16'h0001   // arbitrary value
) (
  input  wire logic               I_CORE_CLK,
  input  wire logic               I_SRST,
  input  wire dsl_pkg::dsl_apb_t  I_APB,
  input  wire dsl_pkg::dsl_plant_t I_PLANT,
  input  wire logic [2:0]         I_KEYS,
  output logic                    O_PREADY,
  output logic                    O_PSLVERR,
  output logic [31:0]             O_PRDATA,
  output logic                    O_SYNC_MOD,
  output logic                    O_FAST_LIMIT_EN,
  output logic                    O_LIMIT_ALARM,
  output logic                    O_SLEEPING,
  output logic                    O_OC_FAULT,
  output logic                    O_DEADBAND_EN,
  output logic                    O_FAN_ON,
  output logic                    O_PID_RUN,
  output logic                    O_KEYPAD_SRC,
  output logic                    O_REVERSE,
  output logic                    O_JOG_FWD,
  output logic                    O_JOG_REV,
  output logic                    O_HALT,
  output logic [15:0]             O_DISP_MASK
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] wake_cfg;     // [15:0] wake_freq, [31:16] wake_delay (0.1 s)
  logic [31:0] sleep_cfg;    // [15:0] sleep_freq, [31:16] sleep_delay (0.1 s)
  logic [31:0] soc_cfg;      // [15:0] threshold 0.1 %, [31:16] delay 10 ms
  logic [15:0] load_speed_factor;
  logic [15:0] run_display_select_mask;
  logic [8:0]  stop_display_select_mask;
  logic [15:0] accumulated_run_hours;
  logic [31:0] load_speed;

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, change accepted when 2 and 3 agree
  // ----------------------------------------------------------------
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw, s1, s2, s3, pin_q;
  assign pin_raw = {I_KEYS, I_PLANT.run_cmd, I_PLANT.fast_limit_active, I_PLANT.hot};

  always_ff @(posedge I_CORE_CLK) begin
    s1 <= pin_raw;
    s2 <= s1;
    s3 <= s2;
  end

  // filtered level, updated only when the last two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
          pin_q[gi] <= 1'b0;
        end else if (s2[gi] == s3[gi]) begin
          pin_q[gi] <= s3[gi];
        end
      end
    end
  endgenerate

  logic [NPIN-1:0] pin_d;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      pin_d <= '0;
    end else begin
      pin_d <= pin_q;
    end
  end

  logic hot, limiting, running;
  logic jog_press, jog_release, halt_press;
  assign hot         = pin_q[0];
  assign limiting    = pin_q[1];
  assign running     = pin_q[2];
  assign halt_press  = pin_q[3] & ~pin_d[3];
  assign jog_release = ~pin_q[4] & pin_d[4];
  assign jog_press   = pin_q[5] & ~pin_d[5];

  // ----------------------------------------------------------------
  // 10 ms tick divider
  // ----------------------------------------------------------------
  logic [19:0] div;
  logic        tick;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || div == 20'(TICK_CYC - 1)) begin
      div  <= '0;
      tick <= ~I_SRST;
    end else begin
      div  <= div + 20'h1;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: one wait state per access, unmapped reads zero with error
  // ----------------------------------------------------------------
  logic access;
  assign access = I_APB.psel & I_APB.penable & ~O_PREADY;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= dsl_pkg::OFS_VERSION) && (a[1:0] == 2'b00);
  endfunction

  // answer one cycle into the access phase
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= access;
      O_PSLVERR <= access & ~mapped(I_APB.paddr);
    end
  end

  // register writes; run hours and status ignore writes
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      ctrl                     <= dsl_pkg::CTRL_RESET;
      wake_cfg                 <= '0;
      sleep_cfg                <= '0;
      soc_cfg                  <= {16'h0000, dsl_pkg::SOC_THR_RESET};
      load_speed_factor        <= dsl_pkg::FACTOR_RESET;
      run_display_select_mask  <= dsl_pkg::RUN_MASK_RESET;
      stop_display_select_mask <= dsl_pkg::STOP_MASK_RESET;
    end else if (access && I_APB.pwrite) begin
      if (I_APB.paddr == dsl_pkg::OFS_CTRL) begin
        ctrl <= I_APB.pwdata;
      end else if (I_APB.paddr == dsl_pkg::OFS_WAKE) begin
        wake_cfg <= I_APB.pwdata;
      end else if (I_APB.paddr == dsl_pkg::OFS_SLEEP) begin
        sleep_cfg <= I_APB.pwdata;
      end else if (I_APB.paddr == dsl_pkg::OFS_SOC) begin
        soc_cfg <= I_APB.pwdata;
      end else if (I_APB.paddr == dsl_pkg::OFS_SPEED) begin
        load_speed_factor <= I_APB.pwdata[15:0];
      end else if (I_APB.paddr == dsl_pkg::OFS_RUN_MASK) begin
        run_display_select_mask <= I_APB.pwdata[15:0];
      end else if (I_APB.paddr == dsl_pkg::OFS_STOP_MASK) begin
        stop_display_select_mask <= I_APB.pwdata[8:0];
      end
    end
  end

  // read mux
  logic [31:0] status_word;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_PRDATA <= '0;
    end else if (access && !I_APB.pwrite) begin
      if (I_APB.paddr == dsl_pkg::OFS_CTRL) begin
        O_PRDATA <= ctrl;
      end else if (I_APB.paddr == dsl_pkg::OFS_WAKE) begin
        O_PRDATA <= wake_cfg;
      end else if (I_APB.paddr == dsl_pkg::OFS_SLEEP) begin
        O_PRDATA <= sleep_cfg;
      end else if (I_APB.paddr == dsl_pkg::OFS_SOC) begin
        O_PRDATA <= soc_cfg;
      end else if (I_APB.paddr == dsl_pkg::OFS_SPEED) begin
        O_PRDATA <= {16'h0000, load_speed_factor};
      end else if (I_APB.paddr == dsl_pkg::OFS_RUN_MASK) begin
        O_PRDATA <= {16'h0000, run_display_select_mask};
      end else if (I_APB.paddr == dsl_pkg::OFS_STOP_MASK) begin
        O_PRDATA <= {23'h000000, stop_display_select_mask};
      end else if (I_APB.paddr == dsl_pkg::OFS_STATUS) begin
        O_PRDATA <= status_word;
      end else if (I_APB.paddr == dsl_pkg::OFS_HOURS) begin
        O_PRDATA <= {16'h0000, accumulated_run_hours};       // see R16
      end else if (I_APB.paddr == dsl_pkg::OFS_LOAD) begin
        O_PRDATA <= load_speed;
      end else if (I_APB.paddr == dsl_pkg::OFS_VERSION) begin
        O_PRDATA <= {16'h0000, VERSION};
      end else begin
        O_PRDATA <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control decode and plain settings
  // ----------------------------------------------------------------
  logic        fast_limit_en, fan_always, stop_any_mode;
  logic [2:0]  jog_key_function;
  logic [1:0]  load_speed_decimals;
  assign fast_limit_en       = ctrl[dsl_pkg::CTRL_FCL_BIT];
  assign fan_always          = ctrl[dsl_pkg::CTRL_FAN_BIT];
  assign stop_any_mode       = ctrl[dsl_pkg::CTRL_STOPK_BIT];
  assign jog_key_function    = ctrl[dsl_pkg::CTRL_JOG_LSB +: 3];
  assign load_speed_decimals = ctrl[dsl_pkg::CTRL_DEC_LSB +: 2];

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_SYNC_MOD      <= 1'b0;
      O_FAST_LIMIT_EN <= 1'b1;
      O_DEADBAND_EN   <= 1'b1;
      O_PID_RUN       <= 1'b0;
    end else begin
      O_SYNC_MOD      <= ctrl[dsl_pkg::CTRL_MOD_BIT];            // see R1
      O_FAST_LIMIT_EN <= fast_limit_en;                          // see R2
      O_DEADBAND_EN   <= ctrl[dsl_pkg::CTRL_DBC_BIT];            // see R11
      O_PID_RUN       <= running | ctrl[dsl_pkg::CTRL_PID_BIT];  // see R24 R8
    end
  end

  // ----------------------------------------------------------------
  // timers: prolonged limit, sleep, wake, overcurrent
  // ----------------------------------------------------------------
  logic limit_exp, sleep_exp, wake_exp, oc_exp;
  logic sleep_en, oc_en, in_sleep;
  assign sleep_en = (wake_cfg[15:0] != 16'h0) || (sleep_cfg[15:0] != 16'h0);  // see R6 R7
  assign oc_en    = soc_cfg[31:16] != 16'h0;                                  // see R10

  dsl_delay_timer #(.W(20)) u_limit (
    .clk(I_CORE_CLK), .srst(I_SRST), .tick(tick),
    .cond(fast_limit_en & limiting & running),
    .limit(20'(LIMIT_TICKS)), .expired(limit_exp));

  // sleep and wake delays in 0.1 s, ten ticks each
  dsl_delay_timer #(.W(20)) u_sleep (
    .clk(I_CORE_CLK), .srst(I_SRST), .tick(tick),
    .cond(sleep_en & running & ~in_sleep & (I_PLANT.set_freq <= sleep_cfg[15:0])),
    .limit(20'(sleep_cfg[31:16] * 20'd10)), .expired(sleep_exp));

  dsl_delay_timer #(.W(20)) u_wake (
    .clk(I_CORE_CLK), .srst(I_SRST), .tick(tick),
    .cond(in_sleep & running & (I_PLANT.set_freq >= wake_cfg[15:0])),
    .limit(20'(wake_cfg[31:16] * 20'd10)), .expired(wake_exp));

  dsl_delay_timer #(.W(20)) u_oc (
    .clk(I_CORE_CLK), .srst(I_SRST), .tick(tick),
    .cond(oc_en & (I_PLANT.out_current >= soc_cfg[15:0])),
    .limit({4'h0, soc_cfg[31:16]}), .expired(oc_exp));

  // sleep state and faults
  assign in_sleep = O_SLEEPING;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_SLEEPING    <= 1'b0;
      O_LIMIT_ALARM <= 1'b0;
      O_OC_FAULT    <= 1'b0;
    end else begin
      if (!sleep_en || !running) begin
        O_SLEEPING <= 1'b0;
      end else if (sleep_exp) begin
        O_SLEEPING <= 1'b1;                      // see R4
      end else if (wake_exp) begin
        O_SLEEPING <= 1'b0;                      // see R5
      end
      O_LIMIT_ALARM <= limit_exp;                // see R3
      O_OC_FAULT    <= oc_exp;                   // see R9
    end
  end

  // ----------------------------------------------------------------
  // fan: hold after stop, then temperature decides
  // ----------------------------------------------------------------
  logic [10:0] fan_cnt;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      fan_cnt <= '0;
      O_FAN_ON <= 1'b0;
    end else if (fan_always) begin
      O_FAN_ON <= 1'b1;                                          // see R13
    end else if (running) begin
      fan_cnt  <= 11'(FAN_TICKS);
      O_FAN_ON <= 1'b1;                                          // see R12
    end else begin
      if (tick && fan_cnt != 11'h0) begin
        fan_cnt <= fan_cnt - 11'h1;
      end
      O_FAN_ON <= (fan_cnt != 11'h0) | hot;                      // see R12
    end
  end

  // ----------------------------------------------------------------
  // run hours: counts whole hours of running, saturates
  // ----------------------------------------------------------------
  logic [18:0] hour_cnt;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      hour_cnt              <= '0;
      accumulated_run_hours <= '0;
    end else if (running && tick) begin
      if (hour_cnt == 19'(HOUR_TICKS - 1)) begin
        hour_cnt <= '0;
        if (accumulated_run_hours != dsl_pkg::HOURS_MAX) begin
          accumulated_run_hours <= accumulated_run_hours + 16'h1;  // see R16
        end
      end else begin
        hour_cnt <= hour_cnt + 19'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // load speed: frequency times factor/10000, shown at chosen decimals
  // ----------------------------------------------------------------
  logic [31:0] prod;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      prod       <= '0;
      load_speed <= '0;
    end else begin
      prod <= (running ? I_PLANT.out_freq : I_PLANT.set_freq)      // see R14 R15
              * load_speed_factor;
      // frequency carries two decimals; rescale to selected places
      case (load_speed_decimals)                                   // see R14
        2'd0:    load_speed <= prod / 32'd1000000;
        2'd1:    load_speed <= prod / 32'd100000;
        2'd2:    load_speed <= prod / 32'd10000;
        default: load_speed <= prod / 32'd1000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // display mask: bit order follows the value list of each state
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_DISP_MASK <= '0;
    end else if (running) begin
      O_DISP_MASK <= run_display_select_mask;                      // see R17 R18
    end else begin
      O_DISP_MASK <= {7'h00, stop_display_select_mask};            // see R17 R19
    end
  end

  // ----------------------------------------------------------------
  // keys: jog function and stop scope
  // ----------------------------------------------------------------
  logic jog_src, jog_dir, jog_fwd, jog_rev;
  always_comb begin
    jog_src = 1'b0;
    jog_dir = 1'b0;
    jog_fwd = 1'b0;
    jog_rev = 1'b0;
    case (jog_key_function)                                        // see R20
      3'd1:    jog_src = ~O_KEYPAD_SRC;
      3'd2:    jog_dir = O_KEYPAD_SRC;                              // see R21
      3'd3:    jog_fwd = 1'b1;
      3'd4:    jog_rev = 1'b1;
      default: jog_src = 1'b0;
    endcase
  end

  assign status_word = {24'h0, O_KEYPAD_SRC, O_REVERSE, O_FAN_ON, O_OC_FAULT,
                        O_LIMIT_ALARM, O_SLEEPING, running, hot};

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_KEYPAD_SRC <= 1'b0;
      O_REVERSE    <= 1'b0;
      O_JOG_FWD    <= 1'b0;
      O_JOG_REV    <= 1'b0;
      O_HALT       <= 1'b0;
    end else begin
      if (jog_press && jog_src) begin
        O_KEYPAD_SRC <= 1'b1;
      end
      if (jog_press && jog_dir) begin
        O_REVERSE <= ~O_REVERSE;
      end
      if (jog_press) begin
        O_JOG_FWD <= jog_fwd;
        O_JOG_REV <= jog_rev;
      end else if (jog_release) begin
        O_JOG_FWD <= 1'b0;
        O_JOG_REV <= 1'b0;
      end
      O_HALT <= halt_press & (stop_any_mode | O_KEYPAD_SRC);       // see R22
    end
  end

endmodule
